// ===== gpio_port.sv
`timescale 1ns/1ps

module gpio_port #(
    parameter int WIDTH = 8
) (
    input wire logic CLK,
    input wire logic RST_B,
    input wire logic CYC_I,
    input wire logic STB_I,
    input wire logic WE_I,
    input wire logic [gpio_port_pkg::ADR_W-1:0] ADR_I,
    input wire logic [gpio_port_pkg::SEL_W-1:0] SEL_I,
    input wire logic [gpio_port_pkg::DAT_W-1:0] DAT_I,
    output logic [gpio_port_pkg::DAT_W-1:0] DAT_O,
    output logic ACK_O,
    input wire logic SLEEP,
    input wire logic STANDBY,
    input wire logic [gpio_port_pkg::SEG_SEL_W-1:0] SEGMENT_SELECT_FIELD,
    input wire logic [WIDTH-1:0] SEGMENT_OUTPUT,
    input wire logic [WIDTH-1:0] GENERAL_IO_PIN_I,
    output logic [WIDTH-1:0] GENERAL_IO_PIN_O,
    output logic [WIDTH-1:0] GENERAL_IO_PIN_OE_B,
    output logic [WIDTH-1:0] PULLUP_EN,
    output logic [WIDTH-1:0] WAKE_REQ_B,
    output logic [WIDTH-1:0] SEGMENT_ENABLE
);

    // ------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------
    logic rst_meta_ff;
    logic rst_sync_ff;

    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            rst_meta_ff <= 1'b0;
            rst_sync_ff <= 1'b0;
        end else begin
            rst_meta_ff <= 1'b1;
            rst_sync_ff <= rst_meta_ff;
        end
    end

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [WIDTH-1:0] data_latch;
        logic [WIDTH-1:0] direction;
        logic [WIDTH-1:0] pu_ctrl;
        logic [WIDTH-1:0] mode;
        logic ack;
        logic [gpio_port_pkg::DAT_W-1:0] rdata;
        logic [WIDTH-1:0] pin_o;
        logic [WIDTH-1:0] pin_oe_b;
        logic [WIDTH-1:0] pu_en;
        logic [WIDTH-1:0] wake_b;
        logic [WIDTH-1:0] seg_en;
    } port_state_s;

    localparam port_state_s RESET_STATE = '{
        data_latch: gpio_port_pkg::RST_PORT_DATA_LATCH,
        direction: gpio_port_pkg::RST_PIN_DIRECTION,
        pu_ctrl: gpio_port_pkg::RST_PULLUP_CONTROL,
        mode: gpio_port_pkg::RST_PIN_FUNCTION_MODE,
        ack: 1'b0,
        rdata: gpio_port_pkg::READ_UNMAPPED,
        pin_o: '0,
        pin_oe_b: '1,
        pu_en: '0,
        wake_b: '1,
        seg_en: '0
    };

    port_state_s state_ff;
    port_state_s nxt_state;

    // ------------------------------------------------------------
    // Pin function selection
    // ------------------------------------------------------------
    logic [WIDTH-1:0] mux_drive;
    logic [WIDTH-1:0] mux_oe_b;
    logic [WIDTH-1:0] mux_pu;
    logic [WIDTH-1:0] mux_wake;
    logic [WIDTH-1:0] mux_seg;
    logic [WIDTH-1:0] mux_read;

    gpio_pin_mux #(
        .WIDTH(WIDTH)
    ) u_pin_mux (
        .dir(state_ff.direction),
        .latch(state_ff.data_latch),
        .pu_ctrl(state_ff.pu_ctrl),
        .mode(state_ff.mode),
        .seg_sel(SEGMENT_SELECT_FIELD),
        .seg_data(SEGMENT_OUTPUT),
        .pin_in(GENERAL_IO_PIN_I),
        .drive(mux_drive),
        .oe_b(mux_oe_b),
        .pu_en(mux_pu),
        .wake(mux_wake),
        .seg_en(mux_seg),
        .read_val(mux_read)
    );

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    logic [gpio_port_pkg::IDX_W-1:0] reg_idx;
    logic access;
    logic wr_en;

    assign reg_idx = ADR_I[gpio_port_pkg::IDX_LSB +: gpio_port_pkg::IDX_W];
    // Answer one cycle after the strobe, then drop for a cycle
    assign access = CYC_I & STB_I & ~state_ff.ack;
    assign wr_en = access & WE_I & SEL_I[gpio_port_pkg::BYTE_LANE];

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        nxt_state = state_ff;
        nxt_state.ack = access;
        nxt_state.rdata = gpio_port_pkg::READ_UNMAPPED;

        if (wr_en) begin
            unique case (reg_idx)
                gpio_port_pkg::IDX_PORT_DATA_LATCH: begin
                    nxt_state.data_latch = DAT_I[WIDTH-1:0];
                end
                gpio_port_pkg::IDX_PIN_DIRECTION: begin
                    nxt_state.direction = DAT_I[WIDTH-1:0];
                end
                gpio_port_pkg::IDX_PULLUP_CONTROL: begin
                    nxt_state.pu_ctrl = DAT_I[WIDTH-1:0];
                end
                gpio_port_pkg::IDX_PIN_FUNCTION_MODE: begin
                    nxt_state.mode = DAT_I[WIDTH-1:0];
                end
                default: begin
                    nxt_state.mode = state_ff.mode;
                end
            endcase
        end

        if (access && !WE_I) begin
            unique case (reg_idx)
                gpio_port_pkg::IDX_PORT_DATA_LATCH: begin
                    nxt_state.rdata[WIDTH-1:0] = mux_read;
                end
                gpio_port_pkg::IDX_PIN_DIRECTION: begin
                    nxt_state.rdata[WIDTH-1:0] = gpio_port_pkg::READ_PIN_DIRECTION;
                end
                gpio_port_pkg::IDX_PULLUP_CONTROL: begin
                    nxt_state.rdata[WIDTH-1:0] = state_ff.pu_ctrl;
                end
                gpio_port_pkg::IDX_PIN_FUNCTION_MODE: begin
                    nxt_state.rdata[WIDTH-1:0] = state_ff.mode;
                end
                default: begin
                    nxt_state.rdata = gpio_port_pkg::READ_UNMAPPED;
                end
            endcase
        end

        // Sleep without standby freezes the pins so the outside world sees no glitch
        if (STANDBY) begin
            nxt_state.pin_oe_b = '1;
            // Pull-ups stay as set so a pulled pin still reads high
            nxt_state.pu_en = mux_pu;
            nxt_state.seg_en = '0;
            nxt_state.wake_b = ~mux_wake;
        end else if (!SLEEP) begin
            nxt_state.pin_o = mux_drive;
            nxt_state.pin_oe_b = mux_oe_b;
            nxt_state.pu_en = mux_pu;
            nxt_state.seg_en = mux_seg;
            nxt_state.wake_b = ~mux_wake;
        end else begin
            // Wake requests must still pass while asleep
            nxt_state.wake_b = ~mux_wake;
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge CLK or negedge rst_sync_ff) begin
        if (!rst_sync_ff) begin
            state_ff <= RESET_STATE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign DAT_O = state_ff.rdata;
    assign ACK_O = state_ff.ack;
    assign GENERAL_IO_PIN_O = state_ff.pin_o;
    assign GENERAL_IO_PIN_OE_B = state_ff.pin_oe_b;
    assign PULLUP_EN = state_ff.pu_en;
    assign WAKE_REQ_B = state_ff.wake_b;
    assign SEGMENT_ENABLE = state_ff.seg_en;

endmodule : gpio_port

// ===== gpio_port_pkg.sv
package gpio_port_pkg;

    // ------------------------------------------------------------
    // Bus geometry
    // ------------------------------------------------------------
    localparam int ADR_W = 18;
    localparam int DAT_W = 32;
    localparam int SEL_W = 4;
    localparam int PORT_W = 8;
    localparam int IDX_W = 16;
    localparam int IDX_LSB = 2;

    // ------------------------------------------------------------
    // Register indices (byte address is four times the index)
    // ------------------------------------------------------------
    localparam logic [IDX_W-1:0] IDX_PIN_FUNCTION_MODE = 16'hffcc;
    localparam logic [IDX_W-1:0] IDX_PORT_DATA_LATCH = 16'hffd8;
    localparam logic [IDX_W-1:0] IDX_PULLUP_CONTROL = 16'hffe2;
    localparam logic [IDX_W-1:0] IDX_PIN_DIRECTION = 16'hffe8;

    // ------------------------------------------------------------
    // Reset and read-back values
    // ------------------------------------------------------------
    localparam logic [PORT_W-1:0] RST_PORT_DATA_LATCH = 8'h00;
    localparam logic [PORT_W-1:0] RST_PIN_DIRECTION = 8'h00;
    localparam logic [PORT_W-1:0] RST_PULLUP_CONTROL = 8'h00;
    localparam logic [PORT_W-1:0] RST_PIN_FUNCTION_MODE = 8'h00;
    localparam logic [PORT_W-1:0] READ_PIN_DIRECTION = 8'hff;
    localparam logic [DAT_W-1:0] READ_UNMAPPED = 32'h0000_0000;

    // ------------------------------------------------------------
    // Segment-select field layout and write byte lane
    // ------------------------------------------------------------
    localparam int SEG_SEL_W = 4;
    localparam int SEG_HI_BIT = 3;
    localparam int SEG_LO_BIT = 0;
    localparam int HALF_W = 4;
    localparam int BYTE_LANE = 0;

endpackage : gpio_port_pkg

// ===== gpio_pin_mux.sv
`timescale 1ns/1ps

module gpio_pin_mux #(
    parameter int WIDTH = 8
) (
    input wire logic [WIDTH-1:0] dir,
    input wire logic [WIDTH-1:0] latch,
    input wire logic [WIDTH-1:0] pu_ctrl,
    input wire logic [WIDTH-1:0] mode,
    input wire logic [gpio_port_pkg::SEG_SEL_W-1:0] seg_sel,
    input wire logic [WIDTH-1:0] seg_data,
    input wire logic [WIDTH-1:0] pin_in,
    output logic [WIDTH-1:0] drive,
    output logic [WIDTH-1:0] oe_b,
    output logic [WIDTH-1:0] pu_en,
    output logic [WIDTH-1:0] wake,
    output logic [WIDTH-1:0] seg_en,
    output logic [WIDTH-1:0] read_val
);

    genvar n;
    generate
        for (n = 0; n < WIDTH; n++) begin : g_pin
            logic is_seg;
            logic is_gio;
            // Upper half follows the high select bit alone, lower half needs both ends
            if (n >= gpio_port_pkg::HALF_W) begin : g_hi
                assign is_seg = seg_sel[gpio_port_pkg::SEG_HI_BIT];
            end else begin : g_lo
                assign is_seg = seg_sel[gpio_port_pkg::SEG_HI_BIT]
                    & seg_sel[gpio_port_pkg::SEG_LO_BIT];
            end
            assign is_gio = ~is_seg & ~mode[n];
            assign seg_en[n] = is_seg;
            assign drive[n] = is_seg ? seg_data[n] : latch[n];
            assign oe_b[n] = ~(is_seg | (is_gio & dir[n]));
            assign pu_en[n] = ~is_seg & ~dir[n] & pu_ctrl[n];
            assign wake[n] = ~is_seg & mode[n] & ~pin_in[n];
            assign read_val[n] = dir[n] ? latch[n] : pin_in[n];
        end
    endgenerate

endmodule : gpio_pin_mux

// ===== gpio_port_assertions.sv
`timescale 1ns/1ps
module gpio_port_assertions (
    input wire logic CLK,
    input wire logic RST_B,
    input wire logic CYC_I,
    input wire logic STB_I,
    input wire logic SLEEP,
    input wire logic STANDBY,
    input wire logic [3:0] SEGMENT_SELECT_FIELD,
    input wire logic [7:0] SEGMENT_OUTPUT,
    input wire logic [31:0] DAT_O,
    input wire logic ACK_O,
    input wire logic [7:0] GENERAL_IO_PIN_O,
    input wire logic [7:0] GENERAL_IO_PIN_OE_B,
    input wire logic [7:0] PULLUP_EN
);
    // ----
    // Checks
    // ----
    // Internal reset lags by two flops, so skip the first edges
    logic [1:0] up_ff;
    logic live;
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) up_ff <= 2'h0;
        else if (up_ff != 2'h3) up_ff <= up_ff + 2'h1;
    end
    assign live = (up_ff == 2'h3);
    default clocking @(posedge CLK); endclocking
    default disable iff (!RST_B);
    a_ack_pulse: assert property (ACK_O |=> !ACK_O)
        else $error("ack longer than one cycle");
    a_ack_timely: assert property (live && CYC_I && STB_I && !ACK_O |=> ACK_O)
        else $error("no ack one cycle after request");
    a_data_idle: assert property (!ACK_O |-> DAT_O == 32'h0000_0000)
        else $error("read data outside ack");
    a_pull_drive: assert property ((PULLUP_EN & ~GENERAL_IO_PIN_OE_B) == 8'h00)
        else $error("pull-up on a driven pin");
    a_seg_upper: assert property ($past(live) && $past(SEGMENT_SELECT_FIELD[3])
        && !$past(SLEEP) && !$past(STANDBY) |-> GENERAL_IO_PIN_OE_B[7:4] == 4'h0)
        else $error("upper pins not segment outputs");
    a_seg_drive: assert property ($past(live) && $past(SEGMENT_SELECT_FIELD[3])
        && !$past(SLEEP) && !$past(STANDBY)
        |-> GENERAL_IO_PIN_O[7:4] == $past(SEGMENT_OUTPUT[7:4]))
        else $error("segment data not on pins");
    a_standby_float: assert property ($past(live) && $past(STANDBY)
        |-> GENERAL_IO_PIN_OE_B == 8'hff)
        else $error("pin driven in standby");
    a_sleep_hold: assert property ($past(live) && $past(SLEEP) && !$past(STANDBY)
        |-> $stable(GENERAL_IO_PIN_OE_B) && $stable(PULLUP_EN))
        else $error("pin state moved in sleep");
endmodule : gpio_port_assertions
bind gpio_port gpio_port_assertions u_chk (.CLK(CLK), .RST_B(RST_B), .CYC_I(CYC_I),
    .STB_I(STB_I), .SLEEP(SLEEP), .STANDBY(STANDBY),
    .SEGMENT_SELECT_FIELD(SEGMENT_SELECT_FIELD), .SEGMENT_OUTPUT(SEGMENT_OUTPUT),
    .DAT_O(DAT_O), .ACK_O(ACK_O), .GENERAL_IO_PIN_O(GENERAL_IO_PIN_O),
    .GENERAL_IO_PIN_OE_B(GENERAL_IO_PIN_OE_B), .PULLUP_EN(PULLUP_EN));

// ===== pin_world.sv
`timescale 1ns/1ps
module pin_world (
    input wire logic clk,
    input wire logic [7:0] drive,
    input wire logic [7:0] oe_b,
    input wire logic [7:0] pu_en,
    input wire logic [7:0] ext_val,
    input wire logic [7:0] ext_en,
    output logic [7:0] level
);
    // ----
    // Wire resolution
    // ----
    // A floating pin toggles so a stale level never reads as valid
    logic [7:0] last_ff = 8'h00;
    always_ff @(posedge clk) last_ff <= level;
    assign level = (~oe_b & drive) | (oe_b & ext_en & ext_val)
        | (oe_b & ~ext_en & (pu_en | ~last_ff));
endmodule : pin_world

// ===== eight_bit_port_with_wakeup_select_test.sv
`timescale 1ns/1ps
module eight_bit_port_with_wakeup_select_test;
    // ----
    // Bench
    // ----
    logic clk = 1'b0, rst_b = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic sleep = 1'b0, stby = 1'b0, ack;
    logic [17:0] adr = '0;
    logic [3:0] sel = '0, sgs = '0;
    logic [31:0] dat_i = '0, dat_o;
    logic [7:0] seg_o = '0, ext = '0, lvl, pin_o, oe_b, pu_en, wake_b, seg_en;
    logic [7:0] ext_on = 8'hff;
    logic [7:0] m_dir, m_lat, m_pu, rd;
    logic [15:0] rnd = 16'h8763;
    logic [15:0] ix [5] = '{gpio_port_pkg::IDX_PIN_FUNCTION_MODE,
        gpio_port_pkg::IDX_PORT_DATA_LATCH, gpio_port_pkg::IDX_PULLUP_CONTROL,
        gpio_port_pkg::IDX_PIN_DIRECTION, 16'h0000};
    int bad_count = 0, checks_done = 0;
    always #50 clk = ~clk;
    gpio_port u_dut (.CLK(clk), .RST_B(rst_b), .CYC_I(cyc), .STB_I(stb), .WE_I(we),
        .ADR_I(adr), .SEL_I(sel), .DAT_I(dat_i), .DAT_O(dat_o), .ACK_O(ack),
        .SLEEP(sleep), .STANDBY(stby), .SEGMENT_SELECT_FIELD(sgs), .SEGMENT_OUTPUT(seg_o),
        .GENERAL_IO_PIN_I(lvl), .GENERAL_IO_PIN_O(pin_o), .GENERAL_IO_PIN_OE_B(oe_b),
        .PULLUP_EN(pu_en), .WAKE_REQ_B(wake_b), .SEGMENT_ENABLE(seg_en));
    pin_world u_pins (.clk(clk), .drive(pin_o), .oe_b(oe_b), .pu_en(pu_en),
        .ext_val(ext), .ext_en(ext_on), .level(lvl));
    function automatic logic [15:0] lfsr(input logic [15:0] x);
        return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction : lfsr
    task automatic wb(input logic w, input int k, input logic [7:0] d, input logic s);
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= {ix[k], 2'b00};
        dat_i <= {24'h00_0000, d};
        sel <= {3'h0, s};
        // Only the watchdog ends a wait for the answer
        do begin
            @(posedge clk);
        end while (ack !== 1'b1);
        rd = dat_o[7:0];
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask : wb
    task automatic settle;
        repeat (2) @(posedge clk);
        #1;
    endtask : settle
    task automatic cmp(input string nm, input logic [7:0] e, input logic [7:0] g);
        checks_done++;
        if (g !== e) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask : cmp
    task automatic end_sim;
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : end_sim
    // Whole run is a few hundred cycles
    initial begin
        #1000000;
        bad_count++;
        end_sim();
    end
    initial begin
        repeat (4) @(posedge clk);
        rst_b <= 1'b1;
        repeat (3) @(posedge clk);
        #1;
        cmp("oe_b", 8'hff, oe_b);
        cmp("wake", 8'hff, wake_b);
        wb(0, 0, 8'h00, 1'b1);
        cmp("mode", 8'h00, rd);
        wb(1, 2, 8'hff, 1'b0);
        wb(0, 2, 8'h00, 1'b1);
        cmp("pull", 8'h00, rd);
        wb(0, 3, 8'h00, 1'b1);
        cmp("dir", 8'hff, rd);
        wb(0, 4, 8'h00, 1'b1);
        cmp("unmapped", 8'h00, rd);
        wb(1, 3, 8'hff, 1'b1);
        wb(0, 1, 8'h00, 1'b1);
        cmp("data", 8'h00, rd);
        $display("test reset values done");
        for (int t = 0; t < 8; t++) begin
            rnd = lfsr(rnd);
            m_dir = rnd[7:0];
            m_lat = rnd[15:8];
            rnd = lfsr(rnd);
            m_pu = rnd[7:0];
            @(posedge clk);
            ext <= rnd[15:8];
            wb(1, 3, m_dir, 1'b1);
            wb(1, 1, m_lat, 1'b1);
            wb(1, 2, m_pu, 1'b1);
            wb(0, 1, 8'h00, 1'b1);
            cmp("data", (m_dir & m_lat) | (~m_dir & rnd[15:8]), rd);
            settle();
            cmp("oe_b", ~m_dir, oe_b);
            cmp("pin_o", m_lat & m_dir, pin_o & m_dir);
            cmp("pull", m_pu & ~m_dir, pu_en);
            wb(0, 2, 8'h00, 1'b1);
            cmp("pull_reg", m_pu, rd);
        end
        $display("test random access done");
        // Released pins must read high through their pull-ups alone
        @(posedge clk);
        ext_on <= 8'h00;
        wb(1, 3, 8'h00, 1'b1);
        wb(1, 2, 8'hff, 1'b1);
        settle();
        wb(0, 1, 8'h00, 1'b1);
        cmp("pulled", 8'hff, rd);
        wb(1, 3, m_dir, 1'b1);
        @(posedge clk);
        ext_on <= 8'hff;
        ext <= 8'h5a;
        wb(1, 0, 8'hff, 1'b1);
        settle();
        cmp("wake", 8'h5a, wake_b);
        cmp("oe_b", 8'hff, oe_b);
        wb(1, 0, 8'h00, 1'b1);
        @(posedge clk);
        seg_o <= 8'hc3;
        sgs <= 4'h8;
        settle();
        cmp("seg_en", 8'hf0, seg_en);
        cmp("seg_pin", 8'hc0, pin_o & 8'hf0);
        @(posedge clk);
        sgs <= 4'h9;
        settle();
        cmp("seg_en", 8'hff, seg_en);
        @(posedge clk);
        sgs <= 4'h0;
        settle();
        cmp("seg_en", 8'h00, seg_en);
        $display("test wake and segment done");
        @(posedge clk);
        sleep <= 1'b1;
        wb(1, 3, ~m_dir, 1'b1);
        settle();
        cmp("oe_b", ~m_dir, oe_b);
        @(posedge clk);
        sleep <= 1'b0;
        stby <= 1'b1;
        settle();
        cmp("oe_b", 8'hff, oe_b);
        @(posedge clk);
        stby <= 1'b0;
        settle();
        cmp("oe_b", m_dir, oe_b);
        @(posedge clk);
        rst_b <= 1'b0;
        repeat (4) @(posedge clk);
        rst_b <= 1'b1;
        repeat (3) @(posedge clk);
        #1;
        cmp("pull", 8'h00, pu_en);
        wb(0, 2, 8'h00, 1'b1);
        cmp("pull", 8'h00, rd);
        $display("test power modes done");
        end_sim();
    end
endmodule : eight_bit_port_with_wakeup_select_test
